// ==== rtl/rsdp_port.sv ====
// raw serial data port: apb registers, bit clock, tx and rx serial paths
// assumes pclk at 200 MHz, demodulator and event inputs on pclk,
// transmit and auxiliary pins asynchronous to pclk
//
// Overview of operation
// R1: field 0: packet engine, port idle
// R2: field 1: event pin on preamble
// R3: field 2: event pin on sync word
// R4: in transmit, modulator takes only pin bits
// R5: transmit drives bit clock, samples data
// R6: host aligns transmit bits to bit clock
// R7: transmit continues until host exit command
// R8: arrival shown in state field, done flag
// R9: receive outputs recovered bits and clock
// R10: enabled event stays active through receive
// R11: strobe is one bit high per byte
// R12: sync strobe marks each byte's first bit
// R13: irq pin: group two full, group one reduced
// R14: latency zero plain, two bits gaussian
// R15: host holds transmit two bits after gaussian
// R16: a0/a3/a6: data always, event pin unused
// R17: other codes: data after preamble detect
// R18: event pin interrupt or strobe by code
// R19: auxiliary pin unused, crystal, or host clock
// R20: host frames start with settling preamble
// R21: sync detection optional, gives byte alignment
// R22: host preamble is repeated 0x55 bytes; host model sends a single 0x55 byte, then 0xc3
// R23: data changes falling, stable at rising
`timescale 1ns/10ps
`include "rsdp_defs.svh"

module rsdp_port
(
   input  wire logic            pclk,          // system clock
   input  wire logic            presetn,       // async reset, low
   input  wire logic            psel,          // apb select
   input  wire logic            penable,       // apb access phase
   input  wire logic            pwrite,        // apb direction
   input  wire rsdp_pkg::rsdp_addr_t paddr,    // apb byte address
   input  wire rsdp_pkg::rsdp_word_t pwdata,   // apb write data
   output logic                 pready,        // apb ready
   output rsdp_pkg::rsdp_word_t prdata,        // apb read data
   output logic                 pslverr,       // apb error
   input  wire logic            demod_bit,     // recovered bit
   input  wire logic            preamble_det,  // preamble pulse
   input  wire logic            sync_det,      // sync word pulse
   input  wire rsdp_pkg::rsdp_byte_t irq_src0, // first group
   input  wire rsdp_pkg::rsdp_byte_t irq_src1, // second group
   input  wire logic            transmit_data_pin,   // host tx bit
   output logic                 receive_data_pin,    // rx bit
   output logic                 shared_serial_clock_pin, // bit clk
   output logic                 receive_event_pin,   // irq/strobe
   output logic                 general_interrupt_pin, // irq
   input  wire logic            aux_in,        // auxiliary pin in
   output logic                 aux_out,       // auxiliary pin out
   output logic                 aux_oe_n,      // aux enable, low
   output logic                 xtal_en,       // crystal on aux
   output logic                 mod_bit,       // to modulator
   output logic                 pkt_mode       // packet engine on
);
   import rsdp_pkg::*;

   // code decoders, shared by logic and checks
   function automatic logic code_valid(input rsdp_byte_t c);
      code_valid = (c >= 8'ha0) && (c <= 8'ha8);
   endfunction

   function automatic logic code_intr(input rsdp_byte_t c);
      code_intr = (c == 8'ha1) || (c == 8'ha4) || (c == 8'ha7);
   endfunction

   function automatic logic code_strobe(input rsdp_byte_t c);
      code_strobe = (c == 8'ha2) || (c == 8'ha5) || (c == 8'ha8);
   endfunction

   function automatic logic code_always(input rsdp_byte_t c);
      code_always = (c == 8'ha0) || (c == 8'ha3) || (c == 8'ha6);
   endfunction

   localparam logic [4:0] BIT_LAST = 5'(`RSDP_BIT_CYC - 1);
   localparam logic [4:0] HALF     = 5'(`RSDP_HALF_CYC);

   rsdp_byte_t  dpc_q;
   rsdp_byte_t  pfs_q;
   logic        gauss_q;
   logic        done_q;
   rsdp_state_t state_q;
   logic        ready_q;
   rsdp_word_t  rdata_q;
   logic        err_q;
   logic        tx_meta_q;
   logic        tx_sync_q;
   logic [4:0]  cnt_q;
   logic        sclk_q;
   logic [1:0]  hist_q;
   logic        mod_q;
   logic        rxd_q;
   logic        pre_seen_q;
   logic        sync_seen_q;
   logic        armed_q;
   logic [2:0]  byte_cnt_q;
   logic        evt_q;
   logic        irq_q;
   logic        aux_clk_q;
   logic        aux_oe_n_q;
   logic        xtal_q;
   logic        pkt_q;

   logic [1:0]  mode;
   logic        raw;
   logic        active;
   logic        rise_evt;
   logic        fall_evt;
   logic        wr_en;
   logic        acc;
   logic [1:0]  cmd;
   logic        arm_evt;

   assign mode     = dpc_q[`RSDP_MODE_LSB +: 2];
   assign raw      = (mode == `RSDP_MODE_PRE) || (mode == `RSDP_MODE_SYNC);
   assign active   = raw && (state_q != ST_IDLE);
   assign rise_evt = active && (cnt_q == HALF - 5'h01);
   assign fall_evt = active && (cnt_q == BIT_LAST);
   assign acc      = psel && penable;
   assign wr_en    = acc && pwrite && ready_q;
   assign cmd      = (wr_en && paddr == `RSDP_CTRL_ADDR)
                     ? pwdata[`RSDP_CMD_LSB +: 2] : 2'h0;
   // preamble or sync word arms the event pin, as the field selects
   assign arm_evt  = (mode == `RSDP_MODE_PRE) ? preamble_det
                     : (mode == `RSDP_MODE_SYNC) ? sync_det : 1'b0;

   // apb answer: ready one cycle into the access phase, data registered
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ready_q <= 1'b0;
         rdata_q <= 32'h0000_0000;
         err_q   <= 1'b0;
      end
      else
      begin
         ready_q <= acc && !ready_q;
         err_q   <= acc && !ready_q &&
                    !(paddr == `RSDP_DPC_ADDR || paddr == `RSDP_PFS_ADDR ||
                      paddr == `RSDP_CTRL_ADDR || paddr == `RSDP_STAT_ADDR);
         case (paddr)
            `RSDP_DPC_ADDR:  rdata_q <= {24'h00_0000, dpc_q};
            `RSDP_PFS_ADDR:  rdata_q <= {24'h00_0000, pfs_q};
            `RSDP_CTRL_ADDR: rdata_q <= {29'h0, gauss_q, 2'h0};
            `RSDP_STAT_ADDR: rdata_q <= {26'h0, sync_seen_q, pre_seen_q,
                                         done_q, state_q};
            default:         rdata_q <= 32'h0000_0000;
         endcase
      end
   end

   // software-written configuration
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         dpc_q   <= `RSDP_DPC_RESET;
         pfs_q   <= `RSDP_PFS_RESET;
         gauss_q <= 1'b0;
      end
      else if (wr_en)
      begin
         if (paddr == `RSDP_DPC_ADDR)
            dpc_q <= pwdata[7:0];
         if (paddr == `RSDP_PFS_ADDR)
            pfs_q <= pwdata[7:0];
         if (paddr == `RSDP_CTRL_ADDR)
            gauss_q <= pwdata[`RSDP_GAUSS_BIT];
      end
   end

   // radio state: only a command leaves transmit
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         state_q <= ST_IDLE;
      else
      begin
         case (cmd)
            `RSDP_CMD_TX: state_q <= ST_TX;             // R7
            `RSDP_CMD_RX: state_q <= ST_RX;
            `RSDP_CMD_ON: state_q <= ST_IDLE;
            default:      state_q <= state_q;
         endcase
      end
   end

   // command done: set on arrival, write one clears, set wins
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         done_q <= 1'b0;
      else if (cmd != 2'h0)
         done_q <= 1'b1;                                // R8
      else if (wr_en && paddr == `RSDP_STAT_ADDR && pwdata[`RSDP_DONE_BIT])
         done_q <= 1'b0;
   end

   // transmit pin is asynchronous: two flops before use
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         tx_meta_q <= 1'b0;
         tx_sync_q <= 1'b0;
      end
      else
      begin
         tx_meta_q <= transmit_data_pin;
         tx_sync_q <= tx_meta_q;
      end
   end

   // bit clock: low first half, high second half, still when idle
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         cnt_q  <= 5'h00;
         sclk_q <= 1'b0;
      end
      else if (!active)
      begin
         cnt_q  <= 5'h00;
         sclk_q <= 1'b0;
      end
      else
      begin
         cnt_q  <= (cnt_q == BIT_LAST) ? 5'h00 : cnt_q + 5'h01;  // R5 R9
         sclk_q <= (cnt_q != BIT_LAST) && (cnt_q >= HALF - 5'h01);
      end
   end

   // transmit: sample at rising edge, no framing, optional two-bit delay
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         hist_q <= 2'h0;
         mod_q  <= 1'b0;
      end
      else if (rise_evt && state_q == ST_TX)
      begin
         hist_q <= {hist_q[0], tx_sync_q};              // R5
         mod_q  <= gauss_q ? hist_q[1] : tx_sync_q;     // R4 R14
      end
   end

   // receive detection flags, cleared on leaving receive
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pre_seen_q  <= 1'b0;
         sync_seen_q <= 1'b0;
      end
      else if (!(active && state_q == ST_RX))
      begin
         pre_seen_q  <= 1'b0;
         sync_seen_q <= 1'b0;
      end
      else
      begin
         pre_seen_q  <= pre_seen_q || preamble_det;
         sync_seen_q <= sync_seen_q || sync_det;        // R21
      end
   end

   // receive data changes on the falling edge, host samples rising
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         rxd_q <= 1'b0;
      else if (!(active && state_q == ST_RX))
         rxd_q <= 1'b0;
      else if (fall_evt)
         rxd_q <= (code_always(pfs_q) || pre_seen_q) && demod_bit; // R9 R16 R17 R23
   end

   // event pin: level interrupt, or byte strobe aligned to detection
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         armed_q    <= 1'b0;
         byte_cnt_q <= 3'h0;
         evt_q      <= 1'b0;
      end
      else if (!(active && state_q == ST_RX))
      begin
         armed_q    <= 1'b0;
         byte_cnt_q <= 3'h0;
         evt_q      <= 1'b0;
      end
      else
      begin
         if (arm_evt)
         begin
            armed_q    <= 1'b1;                         // R2 R3
            byte_cnt_q <= 3'h0;                         // R12
         end
         else if (fall_evt && armed_q)
            byte_cnt_q <= byte_cnt_q + 3'h1;
         if (code_intr(pfs_q))
            evt_q <= armed_q;                           // R10 R18
         else if (code_strobe(pfs_q) && fall_evt)
            evt_q <= armed_q && !arm_evt &&
                     (byte_cnt_q == 3'h0);              // R11 R18
         else if (!code_strobe(pfs_q))
            evt_q <= 1'b0;                              // R16
      end
   end

   // general interrupt: raw mode trims the first group
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         irq_q <= 1'b0;
      else if (raw)
         irq_q <= (|irq_src1) || irq_src0[`RSDP_SRC0_PRE] ||
                  irq_src0[`RSDP_SRC0_SYNC];            // R13
      else
         irq_q <= (|irq_src1) || (|irq_src0);
   end

   // auxiliary pin role and packet engine select
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         aux_clk_q  <= 1'b0;
         aux_oe_n_q <= 1'b1;
         xtal_q     <= 1'b0;
         pkt_q      <= 1'b1;
      end
      else
      begin
         // host clock divided by two; crystal input needs no drive
         aux_clk_q  <= raw && pfs_q >= 8'ha6 && code_valid(pfs_q) &&
                       !aux_clk_q;                       // R19
         aux_oe_n_q <= !(raw && pfs_q >= 8'ha6 && code_valid(pfs_q));
         xtal_q     <= raw && pfs_q >= 8'ha3 && pfs_q <= 8'ha5; // R19
         pkt_q      <= !raw;                            // R1
      end
   end

   assign pready                  = ready_q;
   assign prdata                  = rdata_q;
   assign pslverr                 = err_q;
   assign receive_data_pin        = rxd_q;
   assign shared_serial_clock_pin = sclk_q;
   assign receive_event_pin       = evt_q;
   assign general_interrupt_pin   = irq_q;
   assign aux_out                 = aux_clk_q;
   assign aux_oe_n                = aux_oe_n_q;
   assign xtal_en                 = xtal_q;
   assign mod_bit                 = mod_q;
   assign pkt_mode                = pkt_q;

   default clocking dcb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   sequence s_tx_sample;
      rise_evt && state_q == ST_TX;
   endsequence
   pkt_select_a: assert property (##1 pkt_mode == !$past(raw)) // R1
      else $error("packet select does not follow data path field");
   idle_clock_a: assert property (!active |=> !sclk_q) // R5
      else $error("bit clock moves while port idle");
   tx_plain_a: assert property (s_tx_sample ##0 !gauss_q
                                |=> mod_bit == $past(tx_sync_q)) // R14
      else $error("plain modulation adds latency");
   tx_gauss_a: assert property (s_tx_sample ##0 gauss_q
                                |=> mod_bit == $past(hist_q[1])) // R14
      else $error("gaussian latency not two bits");
   clk_period_a: assert property ($rose(sclk_q) && active
                                  |-> (##25 $rose(sclk_q)) or
                                      (##[1:25] !active)) // R9
      else $error("bit clock period wrong");
   evt_hold_a: assert property (evt_q && code_intr(pfs_q)
                                && state_q == ST_RX && cmd == 2'h0
                                && !wr_en |=> evt_q) // R10
      else $error("receive interrupt dropped inside receive");
   strobe_len_a: assert property ($rose(evt_q) && code_strobe(pfs_q)
                                  && !wr_en |-> ##24
                                  (evt_q || state_q != ST_RX)
                                  ##1 !evt_q) // R11
      else $error("strobe not one bit long");
   evt_unused_a: assert property (code_always(pfs_q) |=> ##1 !evt_q) // R16
      else $error("event pin active for unused code");
   rx_gate_a: assert property (!code_always(pfs_q) && !pre_seen_q
                               && !wr_en |=> !receive_data_pin) // R17
      else $error("receive data before preamble");
   irq_trim_a: assert property (raw && irq_src1 == 8'h00
                                && irq_src0[1:0] == 2'h0
                                |=> !general_interrupt_pin) // R13
      else $error("trimmed interrupt reaches pin");
endmodule

// ==== shared/rsdp_defs.svh ====
// constants of the raw serial data port: offsets, fields, resets, timing
// assumes inclusion by the design file and by the bench
`ifndef RSDP_DEFS_SVH
`define RSDP_DEFS_SVH

// register indices as printed; byte address is four times the index
`define RSDP_DPC_IDX       12'h126
`define RSDP_PFS_IDX       12'h3fa
`define RSDP_DPC_ADDR      12'h498
`define RSDP_PFS_ADDR      12'hfe8
`define RSDP_CTRL_ADDR     12'h000
`define RSDP_STAT_ADDR     12'h004

// data_path_control fields and values
`define RSDP_MODE_LSB      0
`define RSDP_MODE_PKT      2'h0
`define RSDP_MODE_PRE      2'h1
`define RSDP_MODE_SYNC     2'h2
`define RSDP_DPC_RESET     8'h00
`define RSDP_PFS_RESET     8'ha0

// control register fields
`define RSDP_CMD_LSB       0
`define RSDP_GAUSS_BIT     2
`define RSDP_CMD_TX        2'h1
`define RSDP_CMD_RX        2'h2
`define RSDP_CMD_ON        2'h3

// status register fields
`define RSDP_ST_LSB        0
`define RSDP_DONE_BIT      3
`define RSDP_PRE_BIT       4
`define RSDP_SYNC_BIT      5

// first interrupt group: events kept in raw mode
`define RSDP_SRC0_PRE      0
`define RSDP_SRC0_SYNC     1

// bit timing
`define RSDP_CLK_NS        5
`define RSDP_BIT_NS        125
`define RSDP_BIT_CYC       (`RSDP_BIT_NS / `RSDP_CLK_NS)
`define RSDP_HALF_CYC      (`RSDP_BIT_CYC / 2)

`endif

// ==== shared/rsdp_pkg.sv ====
// types of the raw serial data port
// assumes the constants header sits beside it
package rsdp_pkg;
   typedef enum logic [2:0]
   {
      ST_IDLE = 3'b001,
      ST_TX   = 3'b010,
      ST_RX   = 3'b100
   } rsdp_state_t;

   typedef logic [7:0]  rsdp_byte_t;
   typedef logic [11:0] rsdp_addr_t;
   typedef logic [31:0] rsdp_word_t;
endpackage

// ==== test/rsdp_host_model.sv ====
// host side of the raw serial port: sends a fixed frame, captures rx
// assumes the device drives the bit clock and holds it low when idle
`timescale 1ns/10ps

module rsdp_host_model
#(
   parameter logic [15:0] FRAME = 16'h55c3 // preamble byte, then data
)
(
   input  wire logic       sclk,     // device bit clock
   input  wire logic       rx_data,  // device receive data
   output logic            tx_data,  // host transmit bit
   output logic [7:0]      rx_shift  // last eight received bits
);
   logic [15:0] sh_q = FRAME;
   logic [7:0]  cap_q = 8'h00;

   // frame opens with 0x55 so the receiver loops can settle
   assign tx_data = sh_q[15];

   // change on the fall so the bit is steady at the device sample
   always @(negedge sclk)
      sh_q <= {sh_q[14:0], sh_q[15]};

   // capture on the rise, away from the data change
   assign rx_shift = cap_q;
   always @(posedge sclk)
      cap_q <= {cap_q[6:0], rx_data};
endmodule

// ==== test/tb_top.sv ====
// self-checking bench of the raw serial data port over apb
// assumes the design header and package; host model on the link
`timescale 1ns/10ps
`include "rsdp_defs.svh"

module tb_top;
   import rsdp_pkg::*;
   logic       pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   rsdp_addr_t paddr = '0;
   rsdp_word_t pwdata = '0, prdata, rd;
   logic       pready, pslverr, er, transmit_data_pin, receive_data_pin;
   logic       shared_serial_clock_pin, receive_event_pin, mod_bit;
   logic       general_interrupt_pin, aux_out, aux_oe_n, xtal_en, pkt_mode;
   logic       demod_bit = 0, preamble_det = 0, sync_det = 0, aux_in = 0;
   rsdp_byte_t irq_src0 = '0, irq_src1 = '0;
   logic [7:0] rx_shift, c;
   int         mismatches = 0, comparisons = 0, g;
   rsdp_word_t n;

   always #2.5 pclk = ~pclk;

   rsdp_port uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
      .pwdata, .pready, .prdata, .pslverr, .demod_bit, .preamble_det,
      .sync_det, .irq_src0, .irq_src1, .transmit_data_pin,
      .receive_data_pin, .shared_serial_clock_pin, .receive_event_pin,
      .general_interrupt_pin, .aux_in, .aux_out, .aux_oe_n, .xtal_en,
      .mod_bit, .pkt_mode);

   rsdp_host_model host (.sclk(shared_serial_clock_pin),
      .rx_data(receive_data_pin), .tx_data(transmit_data_pin),
      .rx_shift(rx_shift));

   task automatic end_of_test;
      if (mismatches == 0 && comparisons > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] seen, exp);
      comparisons++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("unexpected %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   // one apb transfer; waits for pready, never assumes its latency
   task automatic apb(input logic w, input rsdp_addr_t a,
                      input rsdp_word_t d);
      int k;
      @(posedge pclk);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      k = 0;
      do
      begin
         @(posedge pclk);
         k++;
      end
      while (pready !== 1'b1 && k < 40);
      rd = prdata;
      er = pslverr;
      psel <= 0;
      penable <= 0;
      chk("pready", pready, 1);
      repeat (2) @(posedge pclk);
   endtask

   task automatic wr(input rsdp_addr_t a, input rsdp_word_t d);
      apb(1, a, d);
   endtask

   task automatic rdc(input string nm, input rsdp_addr_t a,
                      input rsdp_word_t e);
      apb(0, a, 0);
      chk(nm, rd, e);
   endtask

   // whole bit periods, sampled mid-cycle so pin updates have landed
   task automatic bits(input int k);
      repeat (k) @(posedge shared_serial_clock_pin);
      #2;
   endtask

   // one-cycle detector pulse: preamble when sy low, sync word when high
   task automatic pulse(input bit sy);
      @(posedge pclk);
      if (sy)
         sync_det <= 1;
      else
         preamble_det <= 1;
      @(posedge pclk);
      sync_det <= 0;
      preamble_det <= 0;
   endtask

   // mod_bit must follow the pin bit, two bits late when gaussian
   task automatic tx_run(input int gs);
      logic [2:0] h;
      h = '0;
      for (int i = 0; i < 16; i++)
      begin
         @(negedge shared_serial_clock_pin);
         h = {h[1:0], transmit_data_pin};
         #2;
         if (i >= 2)
            chk("mod_bit", mod_bit, gs ? h[2] : h[0]);
      end
   endtask

   // hang guard, far beyond the few thousand cycles of the tests
   initial
   begin
      repeat (40000) @(posedge pclk);
      mismatches++;
      end_of_test;
   end

   initial
   begin
      repeat (6) @(posedge pclk);
      presetn <= 1;
      @(posedge pclk);
      chk("pkt_mode", pkt_mode, 1);
      chk("aux_oe_n", aux_oe_n, 1);
      rdc("dpc", `RSDP_DPC_ADDR, 0);
      rdc("pfs", `RSDP_PFS_ADDR, 32'h0000_00a0);
      rdc("unmapped", 12'h100, 0);
      chk("pslverr", er, 1);
      // first group reduced to preamble and sync in raw mode
      irq_src0 <= 8'hfc;
      wr(`RSDP_DPC_ADDR, 1);
      chk("pkt_mode", pkt_mode, 0);
      chk("irq", general_interrupt_pin, 0);
      irq_src1 <= 8'h10;
      wr(`RSDP_PFS_ADDR, 32'h0000_00a0);
      chk("irq", general_interrupt_pin, 1);
      irq_src1 <= 8'h00;
      wr(`RSDP_DPC_ADDR, 0);
      chk("irq", general_interrupt_pin, 1);
      irq_src0 <= 8'h00;
      // every pin-function code, auxiliary pin role
      wr(`RSDP_DPC_ADDR, 1);
      for (c = 8'ha0; c <= 8'ha8; c++)
      begin
         wr(`RSDP_PFS_ADDR, {24'h0, c});
         rdc("pfs", `RSDP_PFS_ADDR, {24'h0, c});
         chk("xtal_en", xtal_en, c >= 8'ha3 && c <= 8'ha5);
         chk("aux_oe_n", aux_oe_n, c < 8'ha6);
         n = aux_out;
         @(posedge pclk);
         chk("aux_out", aux_out, (c >= 8'ha6) ? !n[0] : 1'b0);
      end
      // transmit, plain then gaussian
      for (g = 0; g < 2; g++)
      begin
         wr(`RSDP_CTRL_ADDR, 32'h1 | (g << 2));
         rdc("stat", `RSDP_STAT_ADDR, 32'h0000_000a);
         chk("tx state", rd[3:0], {1'b1, ST_TX});
         wr(`RSDP_STAT_ADDR, 32'h8);
         tx_run(g);
         if (g)
            bits(2);
         wr(`RSDP_CTRL_ADDR, 32'h3);
         apb(0, `RSDP_STAT_ADDR, 0);
         chk("idle state", rd[2:0], ST_IDLE);
         chk("sclk idle", shared_serial_clock_pin, 0);
      end
      // receive, strobe locked to the sync word
      wr(`RSDP_DPC_ADDR, 2);
      wr(`RSDP_PFS_ADDR, 32'h0000_00a2);
      demod_bit <= 1;
      wr(`RSDP_CTRL_ADDR, 32'h2);
      bits(4);
      chk("rx before pre", receive_data_pin, 0);
      pulse(1'b0);
      bits(3);
      chk("rx data", receive_data_pin, 1);
      pulse(1'b1);
      n = 0;
      repeat (24)
      begin
         bits(1);
         n += receive_event_pin;
      end
      chk("strobes", n, 3);
      apb(0, `RSDP_STAT_ADDR, 0);
      chk("seen", rd[5:4], 2'b11);
      wr(`RSDP_CTRL_ADDR, 32'h3);
      // interrupt on preamble, held through receive
      wr(`RSDP_DPC_ADDR, 1);
      wr(`RSDP_PFS_ADDR, 32'h0000_00a1);
      wr(`RSDP_CTRL_ADDR, 32'h2);
      pulse(1'b1);
      bits(2);
      chk("event", receive_event_pin, 0);
      pulse(1'b0);
      bits(10);
      chk("event", receive_event_pin, 1);
      wr(`RSDP_CTRL_ADDR, 32'h3);
      chk("event", receive_event_pin, 0);
      // data at once, event pin unused
      wr(`RSDP_PFS_ADDR, 32'h0000_00a0);
      wr(`RSDP_CTRL_ADDR, 32'h2);
      pulse(1'b0);
      bits(10);
      chk("rx data", receive_data_pin, 1);
      chk("host rx", rx_shift, 8'hff);
      chk("event", receive_event_pin, 0);
      wr(`RSDP_CTRL_ADDR, 32'h3);
      // packet mode keeps the serial pins quiet
      wr(`RSDP_DPC_ADDR, 0);
      wr(`RSDP_CTRL_ADDR, 32'h2);
      repeat (60) @(posedge pclk);
      chk("sclk", shared_serial_clock_pin, 0);
      chk("rx data", receive_data_pin, 0);
      wr(`RSDP_CTRL_ADDR, 32'h3);
      end_of_test;
   end
endmodule
